// File: rtl/backup_save_regs.vh
// Register offsets, fields, reset values and limits of the backup save block
`ifndef BACKUP_SAVE_REGS_VH
`define BACKUP_SAVE_REGS_VH
`define OFS_SAVE_CTRL      4'h0
`define OFS_WORD_COUNT     4'h4
`define OFS_SUBST_ADDR     4'h8
`define OFS_CONFIG         4'hc
`define OFS_SAVE_ENV       4'h0
`define BIT_REQ            0
`define BIT_DONE           1
`define BIT_REPORT         2
`define BIT_PROG_VALID     6
`define BIT_WORD_VALID     7
`define CFG_SUBST_EN       16
`define ENV_RUN            0
`define ENV_CART           1
`define MAX_WORDS          16'h03e8
`define MAX_APP_KW         16'h000f
`define COUNT_NONE         16'hffff
`define ERR_NONE           8'h00
`define ERR_SAVE_CFG       8'h01
`define ERR_RETR_RANGE     8'h02
`define ERR_RETR_CFG       8'h03
`define ERR_APP_SIZE       8'h04
`define ERR_RUN            8'h05
`define ERR_CART           8'h06
`define ERR_FLASH          8'h07
`endif

// File: rtl/program_backup_save_control.v
// Save control sequencer with Wishbone registers and flash request handshake
//
// Added by the designer: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "backup_save_regs.vh"
module program_backup_save_control (
   input  wire        core_clk,
   input  wire        reset,
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [3:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   input  wire        cold_restart,
   input  wire        run_state,
   input  wire        cartridge_present,
   input  wire [15:0] configured_words,
   input  wire [15:0] app_size_kw,
   input  wire        flash_has_words,
   input  wire [15:0] flash_saved_words,
   input  wire        retrieve_check,
   input  wire [15:0] retrieve_count,
   input  wire [7:0]  subst_module,
   input  wire [7:0]  subst_channel,
   output reg         flash_start,
   output reg  [15:0] flash_word_count,
   output reg         flash_erase_words,
   input  wire        flash_done,
   input  wire        flash_fail,
   output reg         program_backup_valid_flag,
   output reg         word_backup_valid_flag
);
   localparam ST_IDLE  = 2'h0;
   localparam ST_CHECK = 2'h1;
   localparam ST_BUSY  = 2'h2;
   localparam ST_DONE  = 2'h3;

   reg [1:0]  state_ff;
   reg [1:0]  nxt_state;
   reg        req_ff;
   reg        req_prev_ff;
   reg        done_ff;
   reg        done_seen_ff;
   reg        report_ff;
   reg [7:0]  err_code_ff;
   reg [15:0] saved_word_count_ff;
   reg        substitute_input_enable_ff;
   reg [15:0] subst_addr_ff;
   reg [7:0]  nxt_err;
   reg [31:0] nxt_rd_data;

   wire       bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire       wr_ctrl  = bus_req & wb_we_i & wb_sel_i[0] &
                         (wb_adr_i == `OFS_SAVE_CTRL);
   wire       wr_count = bus_req & wb_we_i &
                         (wb_adr_i == `OFS_WORD_COUNT);
   wire       wr_cfg   = bus_req & wb_we_i & wb_sel_i[2] &
                         (wb_adr_i == `OFS_CONFIG);
   wire       rd_ctrl  = bus_req & ~wb_we_i &
                         (wb_adr_i == `OFS_SAVE_CTRL);
   wire       req_rise = req_ff & ~req_prev_ff;
   wire [15:0] ctrl_word = {err_code_ff,
                            word_backup_valid_flag,
                            program_backup_valid_flag,
                            3'h0,
                            report_ff, done_ff, req_ff};
   wire       cnt_neg  = saved_word_count_ff[15];

   // Individual refusal causes; a save failing any of them never
   // reaches the flash, so the backup already held stays intact
   wire       err_run  = run_state;
   wire       err_cart = cartridge_present;
   wire       err_size = app_size_kw > `MAX_APP_KW;
   wire       err_cfg  = ~cnt_neg &
                         (saved_word_count_ff > configured_words);

   // Retrieve count screening; a negative count shows as the sign bit
   wire       retr_range = retrieve_count[15] |
                           (retrieve_count > `MAX_WORDS);
   wire       retr_cfg   = retrieve_count > configured_words;

   // Error screening, checked in order of severity
   // Only one code can be shown, so the most basic cause wins
   always @* begin
      nxt_err = `ERR_NONE;
      if (err_run)
         nxt_err = `ERR_RUN;
      else if (err_cart)
         nxt_err = `ERR_CART;
      else if (err_size)
         nxt_err = `ERR_APP_SIZE;
      else if (err_cfg)
         nxt_err = `ERR_SAVE_CFG;
   end

   // Sequencer state register
   always @(posedge core_clk or posedge reset) begin
      if (reset)
         state_ff <= ST_IDLE;
      else
         state_ff <= nxt_state;
   end

   // Next state: one check cycle, then wait for flash answer
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (req_rise)
               nxt_state = ST_CHECK;
         end
         ST_CHECK: begin
            if (nxt_err != `ERR_NONE)
               nxt_state = ST_DONE;
            else
               nxt_state = ST_BUSY;
         end
         ST_BUSY: begin
            if (flash_done)
               nxt_state = ST_DONE;
         end
         ST_DONE: nxt_state = ST_IDLE;
         default: nxt_state = ST_IDLE;
      endcase
   end

   // Request bit: software sets it, hardware clears after the edge
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         req_ff      <= 1'b0;
         req_prev_ff <= 1'b0;
      end else begin
         req_prev_ff <= req_ff;
         if (state_ff == ST_CHECK)
            req_ff <= 1'b0;
         else if (wr_ctrl)
            req_ff <= wb_dat_i[`BIT_REQ];
      end
   end

   // Report and code land in ST_DONE, one cycle ahead of done
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         report_ff   <= 1'b0;
         err_code_ff <= `ERR_NONE;
      end else if (state_ff == ST_CHECK && nxt_err != `ERR_NONE) begin
         report_ff   <= 1'b1;
         err_code_ff <= nxt_err;
      end else if (state_ff == ST_BUSY && flash_done) begin
         report_ff   <= flash_fail;
         err_code_ff <= flash_fail ? `ERR_FLASH : `ERR_NONE;
      end else if (retrieve_check && state_ff == ST_IDLE) begin
         // Retrieve side only reports its count problems here
         if (retr_range) begin
            report_ff   <= 1'b1;
            err_code_ff <= `ERR_RETR_RANGE;
         end else if (retr_cfg) begin
            report_ff   <= 1'b1;
            err_code_ff <= `ERR_RETR_CFG;
         end
      end
   end

   // Completion: set after status, cleared once software read it
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         done_ff      <= 1'b0;
         done_seen_ff <= 1'b0;
      end else begin
         if (state_ff == ST_DONE)
            done_ff <= 1'b1;
         else if (done_seen_ff)
            done_ff <= 1'b0;
         if (state_ff == ST_DONE)
            done_seen_ff <= 1'b0;
         else
            done_seen_ff <= done_ff & rd_ctrl;
      end
   end

   // Flash command; words ride with the program, or are erased for a zero or negative count
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         flash_start       <= 1'b0;
         flash_word_count  <= 16'h0000;
         flash_erase_words <= 1'b0;
      end else begin
         flash_start <= (state_ff == ST_CHECK) &&
                        (nxt_err == `ERR_NONE);
         if (state_ff == ST_CHECK) begin
            if (cnt_neg || saved_word_count_ff == 16'h0000) begin
               flash_word_count  <= 16'h0000;
               flash_erase_words <= 1'b1;
            end else begin
               // Any positive nonzero count moves the first block in full
               flash_word_count  <= `MAX_WORDS;
               flash_erase_words <= 1'b0;
            end
         end
      end
   end

   // Backup validity flags follow the save outcome
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         program_backup_valid_flag <= 1'b0;
         word_backup_valid_flag    <= 1'b0;
      end else if (cold_restart) begin
         program_backup_valid_flag <= 1'b1;
         word_backup_valid_flag    <= flash_has_words;
      end else if (state_ff == ST_BUSY && flash_done) begin
         program_backup_valid_flag <= ~flash_fail;
         word_backup_valid_flag    <= ~flash_fail &
                                      ~flash_erase_words;
      end
   end

   // Byte lanes of the count register, merged before the write so the
   // register keeps a single driver
   wire [15:0] count_wr_data;
   genvar      lane;
   generate
      for (lane = 0; lane < 2; lane = lane + 1) begin : g_count_lane
         assign count_wr_data[8*lane+7:8*lane] =
            wb_sel_i[lane] ? wb_dat_i[8*lane+7:8*lane]
                           : saved_word_count_ff[8*lane+7:8*lane];
      end
   endgenerate

   // Word count register, reloaded on cold restart
   // Cold restart wins over a software write in the same cycle
   always @(posedge core_clk or posedge reset) begin
      if (reset)
         saved_word_count_ff <= `COUNT_NONE;
      else if (cold_restart)
         saved_word_count_ff <= flash_has_words ?
                                flash_saved_words : `COUNT_NONE;
      else if (wr_count)
         saved_word_count_ff <= count_wr_data;
   end

   // Substitute input enable and address; zero while disabled
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         substitute_input_enable_ff <= 1'b0;
         subst_addr_ff              <= 16'h0000;
      end else begin
         if (wr_cfg)
            substitute_input_enable_ff <= wb_dat_i[`CFG_SUBST_EN];
         if (substitute_input_enable_ff)
            subst_addr_ff <= {subst_module, subst_channel};
         else
            subst_addr_ff <= 16'h0000;
      end
   end

   // Read data chosen from the address; unmapped offsets read zero
   always @* begin
      nxt_rd_data = 32'h00000000;
      case (wb_adr_i)
         `OFS_SAVE_CTRL:  nxt_rd_data = {16'h0000, ctrl_word};
         `OFS_WORD_COUNT: nxt_rd_data = {16'h0000, saved_word_count_ff};
         `OFS_SUBST_ADDR: nxt_rd_data = {16'h0000, subst_addr_ff};
         `OFS_CONFIG:     nxt_rd_data = {15'h0000,
                                         substitute_input_enable_ff,
                                         14'h0000, cartridge_present,
                                         run_state};
         default:         nxt_rd_data = 32'h00000000;
      endcase
   end

   // Wishbone slave: one registered ack per request, a cycle after it, unmapped offsets acked too
   // Data is zero outside the ack cycle so stale status never leaks
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req && !wb_we_i)
            wb_dat_o <= nxt_rd_data;
         else
            wb_dat_o <= 32'h00000000;
      end
   end
endmodule

// File: verif/backup_save_monitor.sv
// Port checker for the backup save control block
`timescale 1ns/1ps
module backup_save_monitor (
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [3:0]  wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        run_state,
   input wire logic        cartridge_present,
   input wire logic [15:0] app_size_kw,
   input wire logic        flash_start,
   input wire logic [15:0] flash_word_count,
   input wire logic        flash_erase_words,
   input wire logic        flash_done,
   input wire logic        flash_fail,
   input wire logic        program_backup_valid_flag,
   input wire logic        word_backup_valid_flag
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   wire rd0 = wb_ack_o && !wb_we_i && wb_adr_i == 4'h0;
   // Ack is a single pulse, one cycle after a request is taken
   a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_answer_time: assert property
      (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not one cycle after request");
   a_start_single_pulse: assert property (flash_start |=> !flash_start)
      else $error("flash start not a pulse");
   // A save refused for run state, cartridge or app size must never reach the flash
   a_start_refused_env: assert property (flash_start |->
      !run_state && !cartridge_present && app_size_kw <= 16'h000f)
      else $error("flash started despite error");
   a_word_count_legal: assert property (flash_start |->
      flash_word_count == 16'h0000 || flash_word_count == 16'h03e8)
      else $error("illegal flash word count");
   a_erase_on_zero: assert property
      (flash_start && flash_word_count == 16'h0000 |-> flash_erase_words)
      else $error("zero count without erase");
   a_reserved_read_zero: assert property (rd0 |-> wb_dat_o[5:3] == 3'h0)
      else $error("reserved bits not zero");
   a_valid_bits_mirror: assert property (rd0 |-> wb_dat_o[7:6] ==
      {$past(word_backup_valid_flag), $past(program_backup_valid_flag)})
      else $error("validity bits differ from flags");
   c_save_started: cover property (flash_start);
   c_flash_failed: cover property (flash_done && flash_fail);
   c_subst_read: cover property (wb_ack_o && wb_adr_i == 4'h8);
endmodule
bind program_backup_save_control backup_save_monitor backup_save_monitor_inst (.*);

// File: verif/flash_model.sv
// Behavioural flash answering each write start after a busy period
`timescale 1ns/1ps
module flash_model (
   input  wire logic        core_clk,
   input  wire logic        flash_start,
   input  wire logic [15:0] flash_word_count,
   input  wire logic        fail_mode,
   output logic             flash_done,
   output logic             flash_fail,
   output logic [15:0]      last_cnt
);
   logic [3:0] busy_ff = 4'h0;
   initial begin
      flash_done = 1'b0;
      flash_fail = 1'b0;
      last_cnt = 16'h0;
   end
   // Fail toggles outside done so the design cannot lean on a stale value
   always @(posedge core_clk) begin
      flash_done <= busy_ff == 4'h1;
      flash_fail <= (busy_ff == 4'h1) ? fail_mode : ~flash_fail;
      if (flash_start) begin
         busy_ff <= 4'h8;
         last_cnt <= flash_word_count;
      end else if (busy_ff != 4'h0) begin
         busy_ff <= busy_ff - 4'h1;
      end
   end
endmodule

// File: verif/testbench.sv
// Register level testbench for the backup save control block
`timescale 1ns/1ps
module testbench;
   logic core_clk, reset, cyc, stb, we, cold, run, cart, has_w, rchk, fail;
   logic [3:0] adr;
   logic [31:0] dat, q, rdat;
   logic [15:0] kw, cfg_w, rcnt, cnt_o, last_cnt;
   logic ack, start, erase, done, ffail, pv, wv;
   integer mismatches = 0, n_tests = 0;
   initial begin
      core_clk = 0;
      forever #25 core_clk = ~core_clk;
   end
   program_backup_save_control program_backup_save_control_inst (
      .core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .cold_restart(cold),
      .run_state(run), .cartridge_present(cart), .configured_words(cfg_w),
      .app_size_kw(kw), .flash_has_words(has_w),
      .flash_saved_words(16'h0123), .retrieve_check(rchk),
      .retrieve_count(rcnt), .subst_module(8'h5a), .subst_channel(8'h3c),
      .flash_start(start), .flash_word_count(cnt_o),
      .flash_erase_words(erase), .flash_done(done), .flash_fail(ffail),
      .program_backup_valid_flag(pv), .word_backup_valid_flag(wv));
   flash_model flash_model_inst (.core_clk(core_clk), .flash_start(start),
      .flash_word_count(cnt_o), .fail_mode(fail), .flash_done(done),
      .flash_fail(ffail), .last_cnt(last_cnt));
   task results;
      if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Classic cycle: hold everything until ack is sampled high
   task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      integer k;
      k = 0;
      @(posedge core_clk);
      cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
      do begin
         @(posedge core_clk);
         k++;
      end while (ack !== 1'b1 && k < 40);
      if (k >= 40) mismatches++;
      q = rdat;
      cyc <= 0; stb <= 0;
   endtask
   task pulse_cold(input logic h);
      @(posedge core_clk);
      has_w <= h; cold <= 1;
      @(posedge core_clk);
      cold <= 0;
   endtask
   // One save with the given environment; expects code e and, when e is zero, word count c
   task save(input logic r, cr, f, input logic [15:0] s, n, input logic [7:0] e,
             input logic [15:0] c);
      integer k;
      @(posedge core_clk);
      run <= r; cart <= cr; fail <= f; kw <= s;
      wb(1, 4'h4, {16'h0, n});
      wb(1, 4'h0, 32'h1);
      k = 0;
      do begin
         wb(0, 4'h0, 32'h0);
         k++;
      end while (q[1] !== 1'b1 && k < 40);
      chk("status", {e, 5'h0, e != 8'h0, 2'b10}, {q[15:8], 5'h0, q[2:0]});
      if (e == 8'h0) chk("words", c, last_cnt);
      wb(0, 4'h0, 32'h0);
      chk("done clear", 16'h0, {14'h0, q[1:0]});
   endtask
   initial begin
      {cyc, stb, we, cold, run, cart, has_w, rchk, fail} = 0;
      adr = 0; dat = 0; kw = 16'h0005; cfg_w = 16'h0064; rcnt = 0;
      reset = 1;
      repeat (3) @(posedge core_clk);
      reset <= 0;
      pulse_cold(0);
      wb(0, 4'h4, 32'h0);
      chk("count none", 16'hffff, q[15:0]);
      pulse_cold(1);
      wb(0, 4'h4, 32'h0);
      chk("count saved", 16'h0123, q[15:0]);
      wb(0, 4'h0, 32'h0);
      chk("valid bits", 16'h3, {14'h0, q[7:6]});
      wb(1, 4'hc, 32'h10000);
      wb(0, 4'h8, 32'h0);
      chk("subst addr", 16'h5a3c, q[15:0]);
      save(0, 0, 0, 16'h0005, 16'h0000, 8'h00, 16'h0000);
      save(0, 0, 0, 16'h0005, 16'h0001, 8'h00, 16'h03e8);
      save(1, 0, 0, 16'h0005, 16'h0001, 8'h05, 16'h0);
      save(0, 1, 0, 16'h0005, 16'h0001, 8'h06, 16'h0);
      save(0, 0, 0, 16'h0010, 16'h0001, 8'h04, 16'h0);
      save(0, 0, 0, 16'h000f, 16'h0065, 8'h01, 16'h0);
      save(0, 0, 1, 16'h0005, 16'h0032, 8'h07, 16'h0);
      wb(0, 4'h0, 32'h0);
      chk("no rerun", 16'h0, {15'h0, q[1]});
      rcnt <= 16'h03e9; rchk <= 1;
      wb(0, 4'h0, 32'h0);
      wb(0, 4'h0, 32'h0);
      chk("retr range", 16'h02, {8'h0, q[15:8]});
      rcnt <= 16'h00c8;
      wb(0, 4'h0, 32'h0);
      wb(0, 4'h0, 32'h0);
      chk("retr config", 16'h03, {8'h0, q[15:8]});
      results;
   end
   initial begin
      #(20000 * 50);
      mismatches++;
      results;
   end
endmodule
